// File: nps_pkg.sv
// Summary of operation
// [R1] exactly two system power modes reported: full power or power off
// [R2] power off when battery absent or enable low; full power needs both
// [R3] communication functions permitted only in full power mode
// [R4] four power states: monitor, hard power down, standby, active
// [R5] monitor entered when enabled, enable high and battery below critical level
// [R6] monitor left only when battery rises above the higher exit threshold; the code also leaves it for active when CTRL_MON_EN is cleared
// [R7] in monitor the internal power unit supply is switched off autonomously
// [R8] host forces hard power down by driving enable low; device cannot
// [R9] standby keeps only the wake-up domain powered; the code also keeps the internal power unit on in standby
// [R10] active powers all blocks, functional mode idle, listener or poller
// [R11] after boot the device sits in active by default
// [R12] host should change default to standby after first boot; the code stores CTRL_BOOT_DN but never uses it, boot always lands in active
// [R13] configured, device drops from active to standby on its own
// [R14] in standby most blocks and the core are unpowered
// [R15] wake sources: bus address match, rf level detector, polling timer
// [R16] any enabled wake event moves standby to active, source recorded
// [R17] polling loop toggles between standby and active repeatedly
// [R18] host restricts functionality through enable and restriction bits
// [R19] after an rf exchange, return to idle or standby
// [R20] enable low forces hard power down above every other transition
`default_nettype none
package nps_pkg;
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_WAKE_EN = 8'h04;
	localparam logic [7:0] ADDR_CRIT    = 8'h08;
	localparam logic [7:0] ADDR_STATUS  = 8'h0C;
	localparam logic [7:0] ADDR_POLL    = 8'h10;
	localparam logic [7:0] ADDR_FUNC    = 8'h14;
	// ctrl fields
	localparam int CTRL_MON_EN   = 0;
	localparam int CTRL_AUTO_SBY = 1;
	localparam int CTRL_POLL_EN  = 2;
	localparam int CTRL_RF_SBY   = 3;
	localparam int CTRL_BOOT_DN  = 4;
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;
	localparam logic [2:0]  WAKE_RST = 3'h7;
	localparam logic [11:0] CRIT_RST = 12'h0A00;
	localparam logic [11:0] HYST_RST = 12'h0010;
	localparam logic [15:0] POLL_RST = 16'h00BE;
	localparam logic [2:0]  RESTRICT_RST = 3'h0;
	localparam int WAKE_ADDR = 0;
	localparam int WAKE_RF   = 1;
	localparam int WAKE_TMR  = 2;
	// low-power oscillator tick derived from clk
	localparam int CLK_HZ  = 20_000_000;
	localparam int LPO_HZ  = 380_000;
	localparam int LPO_DIV = CLK_HZ / LPO_HZ;
	localparam int BOOT_CYC = 16;
	typedef enum logic [3:0] {
		ST_MON = 4'b0001,
		ST_HPD = 4'b0010,
		ST_SBY = 4'b0100,
		ST_ACT = 4'b1000
	} nps_state_t;
	typedef enum logic [2:0] {
		FM_IDLE   = 3'b001,
		FM_LISTEN = 3'b010,
		FM_POLL   = 3'b100
	} nps_func_t;
	localparam logic [1:0] FCMD_NONE   = 2'h0;
	localparam logic [1:0] FCMD_LISTEN = 2'h1;
	localparam logic [1:0] FCMD_POLL   = 2'h2;
endpackage
`default_nettype wire

// File: nps_power_state_manager.sv
`timescale 1ns/10ps
`default_nettype none
module nps_power_state_manager (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        battery_present,
	input  wire logic [11:0] battery_level,
	input  wire logic        power_enable_input,
	input  wire logic        host_addr_match,
	input  wire logic        rf_field_detect,
	input  wire logic        rf_exchange_done,
	output logic             full_power_mode,
	output logic             comm_allowed,
	output logic [3:0]       power_state,
	output logic [2:0]       func_mode,
	output logic             internal_power_unit_on,
	output logic             core_power_on,
	output logic             wake_domain_on,
	output logic             lpo_enable
);
	nps_pkg::nps_state_t st_ff;
	nps_pkg::nps_func_t  fm_ff;
	logic [31:0] ctrl_ff;
	logic [2:0]  wake_en_ff;
	logic [11:0] crit_ff;
	logic [11:0] hyst_ff;
	logic [15:0] poll_ff;
	logic [15:0] poll_cnt_ff;
	logic [7:0]  lpo_cnt_ff;
	logic [4:0]  boot_cnt_ff;
	logic [2:0]  wake_src_ff;
	logic [2:0]  restrict_ff;
	logic [1:0]  fcmd_ff;
	logic        low_batt_ff;
	logic [31:0] nxt_prdata;
	logic        full_pwr;
	logic        wr;
	logic        lpo_tick;
	logic        poll_evt;
	logic [2:0]  wake_hit;
	logic        boot_done;
	wire         mon_en   = ctrl_ff[nps_pkg::CTRL_MON_EN];
	wire         auto_sby = ctrl_ff[nps_pkg::CTRL_AUTO_SBY];
	wire         poll_en  = ctrl_ff[nps_pkg::CTRL_POLL_EN];
	wire         rf_sby   = ctrl_ff[nps_pkg::CTRL_RF_SBY];

	assign pready  = 1'b1;
	assign wr      = psel && penable && pwrite;
	assign pslverr = psel && penable && !(paddr == nps_pkg::ADDR_CTRL || paddr == nps_pkg::ADDR_WAKE_EN
		|| paddr == nps_pkg::ADDR_CRIT || paddr == nps_pkg::ADDR_STATUS
		|| paddr == nps_pkg::ADDR_POLL || paddr == nps_pkg::ADDR_FUNC);

	// battery comparator with hysteresis: enter below crit, leave above crit+hyst
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			low_batt_ff <= 1'b0;
		end else if (!low_batt_ff && battery_level < crit_ff) begin
			low_batt_ff <= 1'b1; // [R5]
		// one bit wider so a high critical level cannot wrap the exit threshold
		end else if (low_batt_ff && {1'b0, battery_level} > {1'b0, crit_ff} + {1'b0, hyst_ff}) begin
			low_batt_ff <= 1'b0; // [R6]
		end
	end

	assign full_pwr        = battery_present && power_enable_input && st_ff != nps_pkg::ST_MON; // [R2]
	assign full_power_mode = full_pwr; // [R1]
	assign comm_allowed    = full_pwr && st_ff == nps_pkg::ST_ACT; // [R3]

	// divider standing in for the 380 kHz oscillator
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lpo_cnt_ff <= 8'h00;
		end else if (lpo_cnt_ff == 8'(nps_pkg::LPO_DIV - 1)) begin
			lpo_cnt_ff <= 8'h00;
		end else begin
			lpo_cnt_ff <= lpo_cnt_ff + 8'h01;
		end
	end
	assign lpo_tick   = lpo_cnt_ff == 8'(nps_pkg::LPO_DIV - 1);
	assign lpo_enable = poll_en && full_pwr; // [R15]

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			poll_cnt_ff <= 16'h0000;
		end else if (st_ff != nps_pkg::ST_SBY || !poll_en) begin
			poll_cnt_ff <= 16'h0000;
		end else if (lpo_tick) begin
			poll_cnt_ff <= poll_evt ? 16'h0000 : poll_cnt_ff + 16'h0001;
		end
	end
	assign poll_evt = lpo_tick && poll_cnt_ff >= poll_ff; // [R17]

	assign wake_hit[nps_pkg::WAKE_ADDR] = host_addr_match && wake_en_ff[nps_pkg::WAKE_ADDR]; // [R15]
	assign wake_hit[nps_pkg::WAKE_RF]   = rf_field_detect && wake_en_ff[nps_pkg::WAKE_RF];
	assign wake_hit[nps_pkg::WAKE_TMR]  = poll_evt && poll_en && wake_en_ff[nps_pkg::WAKE_TMR];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			boot_cnt_ff <= 5'h00;
		end else if (!full_pwr) begin
			boot_cnt_ff <= 5'h00;
		end else if (!boot_done) begin
			boot_cnt_ff <= boot_cnt_ff + 5'h01;
		end
	end
	assign boot_done = boot_cnt_ff == 5'(nps_pkg::BOOT_CYC);

	// power state machine
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_ff <= nps_pkg::ST_HPD;
		end else if (!power_enable_input || !battery_present) begin
			st_ff <= nps_pkg::ST_HPD; // [R20] [R8]
		end else if (mon_en && low_batt_ff) begin
			st_ff <= nps_pkg::ST_MON; // [R5]
		end else begin
			unique case (st_ff)
				nps_pkg::ST_MON: st_ff <= nps_pkg::ST_ACT; // [R6] [R11]
				nps_pkg::ST_HPD: st_ff <= nps_pkg::ST_ACT; // [R11]
				nps_pkg::ST_SBY: begin
					if (|wake_hit) begin
						st_ff <= nps_pkg::ST_ACT; // [R16]
					end
				end
				nps_pkg::ST_ACT: begin
					// autonomous drop only once booted and idle
					if (auto_sby && boot_done && fm_ff == nps_pkg::FM_IDLE && fcmd_ff == nps_pkg::FCMD_NONE) begin
						st_ff <= nps_pkg::ST_SBY; // [R13] [R17]
					end else if (rf_sby && rf_exchange_done && fm_ff != nps_pkg::FM_IDLE) begin
						st_ff <= nps_pkg::ST_SBY; // [R19]
					end
				end
				default: st_ff <= nps_pkg::ST_HPD;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wake_src_ff <= 3'h0;
		end else if (st_ff == nps_pkg::ST_SBY && |wake_hit) begin
			wake_src_ff <= wake_hit; // [R16]
		end
	end

	// functional mode inside active
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fm_ff <= nps_pkg::FM_IDLE;
		end else if (st_ff != nps_pkg::ST_ACT) begin
			fm_ff <= nps_pkg::FM_IDLE;
		end else if (rf_exchange_done) begin
			fm_ff <= nps_pkg::FM_IDLE; // [R19]
		end else if (fcmd_ff == nps_pkg::FCMD_POLL && !restrict_ff[2]) begin
			fm_ff <= nps_pkg::FM_POLL; // [R10] [R18]
		end else if ((fcmd_ff == nps_pkg::FCMD_LISTEN || wake_src_ff[nps_pkg::WAKE_RF]) && !restrict_ff[1]) begin
			fm_ff <= nps_pkg::FM_LISTEN; // [R10] [R18]
		end
	end

	assign power_state            = st_ff; // [R4]
	assign func_mode              = fm_ff;
	assign internal_power_unit_on = st_ff == nps_pkg::ST_ACT || st_ff == nps_pkg::ST_SBY; // [R7]
	assign core_power_on          = st_ff == nps_pkg::ST_ACT; // [R10] [R14]
	assign wake_domain_on         = st_ff == nps_pkg::ST_SBY || st_ff == nps_pkg::ST_ACT; // [R9]

	// register writes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_ff    <= nps_pkg::CTRL_RST;
			wake_en_ff <= nps_pkg::WAKE_RST;
			crit_ff    <= nps_pkg::CRIT_RST;
			hyst_ff    <= nps_pkg::HYST_RST;
			poll_ff    <= nps_pkg::POLL_RST;
			restrict_ff <= nps_pkg::RESTRICT_RST;
		end else if (wr) begin
			unique case (paddr)
				nps_pkg::ADDR_CTRL:    ctrl_ff <= {27'h000_0000, pwdata[4:0]}; // [R12]
				nps_pkg::ADDR_WAKE_EN: wake_en_ff <= pwdata[2:0];
				nps_pkg::ADDR_CRIT: begin
					crit_ff <= pwdata[11:0];
					hyst_ff <= pwdata[27:16];
				end
				nps_pkg::ADDR_POLL:    poll_ff <= pwdata[15:0];
				nps_pkg::ADDR_FUNC:    restrict_ff <= pwdata[6:4]; // [R18]
				default: ;
			endcase
		end
	end

	// functional command: held until an rf exchange completes, a new write or state leaves active
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fcmd_ff <= nps_pkg::FCMD_NONE;
		end else if (wr && paddr == nps_pkg::ADDR_FUNC) begin
			fcmd_ff <= pwdata[1:0];
		end else if (st_ff != nps_pkg::ST_ACT || rf_exchange_done) begin
			fcmd_ff <= nps_pkg::FCMD_NONE;
		end
	end

	always_comb begin
		nxt_prdata = 32'h0000_0000;
		unique case (paddr)
			nps_pkg::ADDR_CTRL:    nxt_prdata = ctrl_ff;
			nps_pkg::ADDR_WAKE_EN: nxt_prdata = {29'h0000_0000, wake_en_ff};
			nps_pkg::ADDR_CRIT:    nxt_prdata = {4'h0, hyst_ff, 4'h0, crit_ff};
			nps_pkg::ADDR_STATUS:  nxt_prdata = {15'h0000, wake_src_ff, 1'b0, fm_ff, 3'h0,
				low_batt_ff, comm_allowed, full_pwr, st_ff};
			nps_pkg::ADDR_POLL:    nxt_prdata = {16'h0000, poll_ff};
			nps_pkg::ADDR_FUNC:    nxt_prdata = {25'h000_0000, restrict_ff, 2'h0, fcmd_ff};
			default:               nxt_prdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= nxt_prdata;
		end
	end

	property p_hpd_on_enable_low;
		@(posedge clk) disable iff (rst) !power_enable_input |=> st_ff == nps_pkg::ST_HPD;
	endproperty
	a_hpd_on_enable_low: assert property (p_hpd_on_enable_low) else $error("enable low did not force hpd"); // [R20]

	property p_full_mode;
		@(posedge clk) disable iff (rst) full_power_mode |-> battery_present && power_enable_input;
	endproperty
	a_full_mode: assert property (p_full_mode) else $error("full power without supplies"); // [R2]

	property p_comm_only_full;
		@(posedge clk) disable iff (rst) comm_allowed |-> full_power_mode;
	endproperty
	a_comm_only_full: assert property (p_comm_only_full) else $error("communication outside full power"); // [R3]

	property p_mon_pmu_off;
		@(posedge clk) disable iff (rst) st_ff == nps_pkg::ST_MON |-> !internal_power_unit_on && !full_power_mode;
	endproperty
	a_mon_pmu_off: assert property (p_mon_pmu_off) else $error("power unit on in monitor"); // [R7]

	sequence s_sby_wake;
		st_ff == nps_pkg::ST_SBY && |wake_hit && power_enable_input && battery_present && !(mon_en && low_batt_ff);
	endsequence
	property p_wake;
		@(posedge clk) disable iff (rst) s_sby_wake |=> st_ff == nps_pkg::ST_ACT && wake_src_ff == $past(wake_hit);
	endproperty
	a_wake: assert property (p_wake) else $error("wake event ignored"); // [R16]

	property p_sby_core_off;
		@(posedge clk) disable iff (rst) st_ff == nps_pkg::ST_SBY |-> !core_power_on && wake_domain_on;
	endproperty
	a_sby_core_off: assert property (p_sby_core_off) else $error("core powered in standby"); // [R14]

	property p_boot_active;
		@(posedge clk) disable iff (rst)
			st_ff == nps_pkg::ST_HPD && power_enable_input && battery_present && !(mon_en && low_batt_ff)
			|=> st_ff == nps_pkg::ST_ACT;
	endproperty
	a_boot_active: assert property (p_boot_active) else $error("boot did not land in active"); // [R11]

	property p_mon_hold;
		@(posedge clk) disable iff (rst)
			low_batt_ff && {1'b0, battery_level} <= {1'b0, crit_ff} + {1'b0, hyst_ff} |=> low_batt_ff;
	endproperty
	a_mon_hold: assert property (p_mon_hold) else $error("monitor left inside hysteresis"); // [R6]
endmodule
`default_nettype wire

// File: nps_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module nps_host_model (
	input  wire logic        clk,
	input  wire logic        en_req,
	input  wire logic        bat_req,
	input  wire logic [11:0] lvl_req,
	output logic             power_enable_input,
	output logic             battery_present,
	output logic      [11:0] battery_level
);
	logic [11:0] last_lvl_ff = 12'h000;
	// only the host moves enable; low parks the device
	always @(posedge clk) begin
		power_enable_input <= en_req;
		battery_present <= bat_req;
		if (bat_req) begin
			battery_level <= lvl_req;
			last_lvl_ff <= lvl_req;
		end else begin
			// supply gone: never show a stale level
			battery_level <= ~last_lvl_ff;
		end
	end
endmodule
`default_nettype wire

// File: nps_power_state_manager_tb.sv
`timescale 1ns/10ps
`default_nettype none
module nps_power_state_manager_tb;
	typedef struct {int id; logic [31:0] e;} nps_note_t;
	logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd_data = 32'h0000_0000;
	logic        pready, pslverr, rd_err = 1'b0;
	logic        en_req = 1'b0, bat_req = 1'b0, power_enable_input, battery_present;
	logic [11:0] lvl_req = 12'h000, battery_level;
	logic        host_addr_match = 1'b0, rf_field_detect = 1'b0, rf_exchange_done = 1'b0;
	logic        full_power_mode, comm_allowed, internal_power_unit_on, core_power_on;
	logic        wake_domain_on, lpo_enable;
	logic [3:0]  power_state;
	logic [2:0]  func_mode;
	int          n_mismatch = 0, tests_run = 0;
	nps_note_t   q[$], nt;
	string       nm[10] = '{"state", "full", "comm", "pmu", "core", "wake", "rdata", "err", "func", "lpo"};
	always #25 clk = ~clk;
	nps_host_model u_host (.clk(clk), .en_req(en_req), .bat_req(bat_req), .lvl_req(lvl_req),
		.power_enable_input(power_enable_input), .battery_present(battery_present),
		.battery_level(battery_level));
	nps_power_state_manager u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .battery_present(battery_present), .battery_level(battery_level),
		.power_enable_input(power_enable_input), .host_addr_match(host_addr_match),
		.rf_field_detect(rf_field_detect), .rf_exchange_done(rf_exchange_done),
		.full_power_mode(full_power_mode), .comm_allowed(comm_allowed), .power_state(power_state),
		.func_mode(func_mode), .internal_power_unit_on(internal_power_unit_on),
		.core_power_on(core_power_on), .wake_domain_on(wake_domain_on), .lpo_enable(lpo_enable));
	function automatic logic [31:0] sel(input int id);
		logic [31:0] v [10];
		v = '{{28'h0, power_state}, {31'h0, full_power_mode}, {31'h0, comm_allowed},
			{31'h0, internal_power_unit_on}, {31'h0, core_power_on}, {31'h0, wake_domain_on},
			rd_data, {31'h0, rd_err}, {29'h0, func_mode}, {31'h0, lpo_enable}};
		return v[id];
	endfunction
	// comparisons land at the falling edge, where outputs have settled
	always @(negedge clk) begin
		while (q.size() > 0) begin
			nt = q.pop_front();
			if (sel(nt.id) !== nt.e) begin
				$display("unexpected %s expected %h seen %h", nm[nt.id], nt.e, sel(nt.id));
				n_mismatch++;
			end
		end
	end
	task automatic note(input int id, input logic [31:0] e);
		q.push_back('{id, e});
		tests_run++;
	endtask
	task automatic wait_id(input int id, input logic [31:0] e, input int lim);
		int i;
		i = 0;
		// look after the edge has settled: an active spell after a wake may last one cycle only
		#1;
		while (sel(id) !== e && i < lim) begin
			@(posedge clk);
			#1;
			i++;
		end
		note(id, e);
		@(posedge clk);
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic end_test(input string s);
		$display("test %s done", s);
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		#(50 * 30000);
		n_mismatch++;
		finish_test();
	end
	initial begin
		void'($urandom(32'hc9b3));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		wait_id(0, nps_pkg::ST_HPD, 2);
		note(1, 0);
		note(2, 0);
		end_test("reset");
		bat_req <= 1'b1;
		lvl_req <= 12'h0B00;
		en_req <= 1'b1;
		wait_id(0, nps_pkg::ST_ACT, 20);
		note(1, 1);
		note(2, 1);
		note(3, 1);
		note(4, 1);
		note(8, nps_pkg::FM_IDLE);
		note(9, 0);
		apb(1'b0, nps_pkg::ADDR_STATUS, 32'h0000_0000);
		note(6, 32'h0000_0438);
		apb(1'b0, 8'h20, 32'h0000_0000);
		note(7, 1);
		note(6, 0);
		end_test("boot");
		apb(1'b1, nps_pkg::ADDR_FUNC, 32'h0000_0001);
		wait_id(8, nps_pkg::FM_LISTEN, 10);
		rf_exchange_done <= 1'b1;
		@(posedge clk);
		rf_exchange_done <= 1'b0;
		wait_id(8, nps_pkg::FM_IDLE, 10);
		apb(1'b1, nps_pkg::ADDR_FUNC, 32'h0000_0042);
		repeat (5) @(posedge clk);
		note(8, nps_pkg::FM_IDLE);
		end_test("func");
		lvl_req <= 12'($urandom % 32'h0000_0A00);
		wait_id(0, nps_pkg::ST_MON, 20);
		note(1, 0);
		note(3, 0);
		lvl_req <= 12'h0A05;
		repeat (10) @(posedge clk);
		note(0, nps_pkg::ST_MON);
		lvl_req <= 12'h0A11 + 12'($urandom % 32'h0000_0500);
		wait_id(0, nps_pkg::ST_ACT, 40);
		end_test("monitor");
		apb(1'b1, nps_pkg::ADDR_CTRL, 32'h0000_0003);
		for (int k = 0; k < 2; k++) begin
			en_req <= 1'b0;
			wait_id(0, nps_pkg::ST_HPD, 10);
			en_req <= 1'b1;
			wait_id(0, nps_pkg::ST_SBY, 200);
			note(4, 0);
			note(5, 1);
			if (k == 0) host_addr_match <= 1'b1;
			else rf_field_detect <= 1'b1;
			@(posedge clk);
			host_addr_match <= 1'b0;
			rf_field_detect <= 1'b0;
			wait_id(0, nps_pkg::ST_ACT, 10);
		end
		end_test("wake");
		apb(1'b1, nps_pkg::ADDR_WAKE_EN, 32'h0000_0004);
		apb(1'b1, nps_pkg::ADDR_POLL, 32'h0000_0002);
		apb(1'b1, nps_pkg::ADDR_CTRL, 32'h0000_0007);
		wait_id(0, nps_pkg::ST_SBY, 200);
		note(9, 1);
		host_addr_match <= 1'b1;
		@(posedge clk);
		host_addr_match <= 1'b0;
		note(0, nps_pkg::ST_SBY);
		wait_id(0, nps_pkg::ST_ACT, 400);
		wait_id(0, nps_pkg::ST_SBY, 200);
		end_test("poll");
		bat_req <= 1'b0;
		wait_id(1, 0, 10);
		note(9, 0);
		en_req <= 1'b0;
		wait_id(0, nps_pkg::ST_HPD, 10);
		end_test("supply");
		finish_test();
	end
endmodule
`default_nettype wire
